// ===== logic/adts_cfg.svh
// constants of the converter control block and its cpu end
// assumes one 125 MHz clock shared by both ends
`ifndef ADTS_CFG_SVH
`define ADTS_CFG_SVH

// state time = four clocks (32 ns)
`define ADTS_DIV_W        2
`define ADTS_DIV_LAST     2'h3
// conversion timing in state times, counted from the start tick
`define ADTS_CNT_W        6
`define ADTS_BUSY_LAST    6'h07
`define ADTS_CONV_LAST    6'h27

// device register byte offsets
`define ADTS_OFF_RESULT   8'h0A
`define ADTS_OFF_CMD      8'h0C
`define ADTS_OFF_TEST     8'h0E
`define ADTS_OFF_SCTRL    8'h10
`define ADTS_OFF_SCOUNT   8'h12
`define ADTS_OFF_STABLE   8'h14
`define ADTS_OFF_SREG     8'h16

// command fields
`define ADTS_CMD_GO       3
`define ADTS_CMD_DIR      4
`define ADTS_CMD_THR      5
`define ADTS_CMD_NONE     8'h00
// test fields
`define ADTS_TST_EN       0
`define ADTS_TST_REF      1
`define ADTS_TST_OFF_LO   2
`define ADTS_OFF_P25      2'h1
`define ADTS_OFF_M25      2'h2
`define ADTS_OFF_M50      2'h3
// result fields
`define ADTS_RES_VAL_LO   6
// scan control fields
`define ADTS_SC_SEL       0
`define ADTS_SC_SRV       1
`define ADTS_SC_UPD       2
`define ADTS_CNT_ONE      8'h01
`define ADTS_PTR_STEP     16'h0002
`define ADTS_REG_STEP     8'h02

// apb map of the cpu end
`define ADTS_APB_ACC      12'h000
`define ADTS_APB_DAT      12'h004
`define ADTS_APB_EVT      12'h008
`define ADTS_APB_TBL_HI   5'h01
`define ADTS_APB_WE_BIT   8
`define ADTS_TBL_IW       5
`define ADTS_TBL_N        32

`endif

// ===== logic/adts_conv.sv
// conversion sequencer: counts state times, busy and done
// assumes tick_i is a one-cycle state-time enable
`timescale 1ns/100ps
`default_nettype none
`include "adts_cfg.svh"
module adts_conv (
  input  wire logic mclk_i,
  input  wire logic rst_b_i,
  input  wire logic tick_i,
  input  wire logic start_i,
  input  wire logic abort_i,
  output logic      busy_o,
  output logic      done_o
);
  logic [`ADTS_CNT_W-1:0] cnt_q;
  logic                   run_q;
  logic                   busy_q;
  logic                   busy_hit;

  assign busy_hit = run_q && tick_i && (cnt_q == `ADTS_BUSY_LAST);
  // done and busy clear share one edge with the result update
  assign done_o   = run_q && tick_i && (cnt_q == `ADTS_CONV_LAST) && !abort_i;
  assign busy_o   = busy_q;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      run_q  <= 1'b0;
      cnt_q  <= '0;
      busy_q <= 1'b0;
    end else if (abort_i) begin
      run_q  <= 1'b0;
      busy_q <= 1'b0;
    end else if (start_i) begin
      run_q  <= 1'b1;
      cnt_q  <= '0;
      busy_q <= 1'b0;
    end else if (done_o) begin
      run_q  <= 1'b0;
      busy_q <= 1'b0;
    end else if (run_q && tick_i) begin
      cnt_q <= cnt_q + 1'b1;
      if (busy_hit) begin
        busy_q <= 1'b1;
      end
    end
  end
endmodule : adts_conv
`default_nettype wire

// ===== logic/adts_cpu.sv
// cpu end: apb slave that issues device accesses and holds the scan table
// assumes one clock with the device end; apb pclk is mclk_i
`timescale 1ns/100ps
`default_nettype none
`include "adts_cfg.svh"
module adts_cpu
  import adts_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        rst_b_i,
  adts_if.cpu              bus,
  input  wire logic [11:0] paddr_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o
);
  logic [15:0] tbl_q [`ADTS_TBL_N];
  logic [15:0] wdat_q;
  logic [15:0] rdat_q;
  logic        evt_q;
  logic        await_q;
  logic        accd_q;
  logic [31:0] prdata_q;
  logic        mack_q;
  logic [15:0] mrd_q;

  logic        acc_hit;
  logic        dat_hit;
  logic        evt_hit;
  logic        tbl_hit;
  logic        mapped;
  logic        setup;
  logic        access;
  logic        xfer;
  logic        areq;
  logic [`ADTS_TBL_IW-1:0] tix;
  logic [`ADTS_TBL_IW-1:0] mix;

  assign acc_hit = (paddr_i == `ADTS_APB_ACC);
  assign dat_hit = (paddr_i == `ADTS_APB_DAT);
  assign evt_hit = (paddr_i == `ADTS_APB_EVT);
  assign tbl_hit = (paddr_i[11:7] == `ADTS_APB_TBL_HI) && (paddr_i[1:0] == 2'b00);
  assign mapped  = acc_hit || dat_hit || evt_hit || tbl_hit;
  assign tix     = paddr_i[`ADTS_TBL_IW+1:2];
  assign mix     = bus.mem_addr[`ADTS_TBL_IW:1];
  assign setup   = psel_i && !penable_i;
  assign access  = psel_i && penable_i;
  // table writes wait a cycle when the server owns the table port
  assign pready_o = (acc_hit && pwrite_i) ? accd_q :
                    (tbl_hit && pwrite_i) ? !bus.mem_req : 1'b1;
  assign pslverr_o = access && !mapped;
  assign xfer     = access && pready_o;
  assign prdata_o = prdata_q;

  // device access is issued once per acc write, answered by reg_ack
  assign areq          = access && acc_hit && pwrite_i && !await_q && !accd_q;
  assign bus.reg_req   = areq;
  assign bus.reg_we    = pwdata_i[`ADTS_APB_WE_BIT];
  assign bus.reg_addr  = pwdata_i[7:0];
  assign bus.reg_wdata = wdat_q;
  assign bus.mem_ack   = mack_q;
  assign bus.mem_rdata = mrd_q;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      await_q  <= 1'b0;
      accd_q   <= 1'b0;
      wdat_q   <= 16'h0000;
      rdat_q   <= 16'h0000;
      evt_q    <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      if (areq) begin
        await_q <= 1'b1;
      end else if (bus.reg_ack) begin
        await_q <= 1'b0;
      end
      if (bus.reg_ack) begin
        accd_q <= 1'b1;
        rdat_q <= bus.reg_rdata;
      end else if (xfer && acc_hit) begin
        accd_q <= 1'b0;
      end
      if (xfer && dat_hit && pwrite_i) begin
        wdat_q <= pwdata_i[15:0];
      end
      // a new done wins over a clear in the same cycle
      evt_q <= bus.done || (evt_q && !(xfer && evt_hit && pwrite_i && pwdata_i[0]));
      if (setup) begin
        if (dat_hit) begin
          prdata_q <= {16'h0000, rdat_q};
        end else if (evt_hit) begin
          prdata_q <= {30'h0000_0000, bus.srv, evt_q};
        end else if (tbl_hit) begin
          prdata_q <= {16'h0000, tbl_q[tix]};
        end else begin
          prdata_q <= 32'h0000_0000;
        end
      end
    end
  end

  // table port for the scan server, answered one cycle after mem_req
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mack_q <= 1'b0;
      mrd_q  <= 16'h0000;
    end else begin
      mack_q <= bus.mem_req;
      if (bus.mem_req) begin
        mrd_q <= tbl_q[mix];
      end
    end
  end

  for (genvar i = 0; i < `ADTS_TBL_N; i++) begin : g_tbl
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        tbl_q[i] <= 16'h0000;
      end else if (bus.mem_req && bus.mem_we && (mix == `ADTS_TBL_IW'(i))) begin
        tbl_q[i] <= bus.mem_wdata;
      end else if (xfer && tbl_hit && pwrite_i && (tix == `ADTS_TBL_IW'(i))) begin
        tbl_q[i] <= pwdata_i[15:0];
      end
    end
  end
endmodule : adts_cpu
`default_nettype wire

// ===== logic/adts_dev.sv
// converter device end: command, test and result registers, scan server
// assumes the cpu end serves table memory and issues register accesses
// Behaviour
// - test enable converts internal level, not channel
// - test source one is reference, zero ground
// - offset field corrects result automatically
// - software writes zero to test upper bits
// - software selects channel seven for tests
// - result low three bits hold channel
// - busy set eight state times after start
// - software ignores result bits four, five
// - value in top bits; eight-bit in 15:8
// - threshold loaded, conversions repeat until crossing
// - crossing stops conversions, raises interrupt pending
// - scan runs up to 256 conversions
// - read command word, advance table pointer two
// - store register at table, write command next
// - optional pointer update, count down, finish
// - register pointer stays in register space
// - zero command starts no conversion
// - software starts first scan conversion itself
// - channel from command low three bits
// - go bit starts soon, else event trigger
// - direction bit picks above or below
// - command write aborts and restarts conversion
`timescale 1ns/100ps
`default_nettype none
`include "adts_cfg.svh"
module adts_dev
  import adts_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        rst_b_i,
  adts_if.dev              bus,
  input  wire logic        epa_trig_i,
  input  wire logic [10:0] ana_raw_i,
  output logic      [2:0]  ana_ch_o,
  output logic             ana_test_o,
  output logic             ana_ref_o,
  output logic             conv_int_o
);
  logic [`ADTS_DIV_W-1:0] div_q;
  logic [7:0]             cmd_q, cnt_q, rp_q, sav_q, haddr_q;
  logic [3:0]             test_q;
  logic [9:0]             res_val_q;
  logic [2:0]             res_ch_q, sc_q;
  logic [15:0]            tp_q, hwd_q, rdata_q, maddr_q, mwd_q;
  adts_cv_t               cv_q;
  adts_srv_t              sv_q;
  logic                   hpend_q, hwe_q, ack_q, mreq_q, mwe_q, int_q;
  logic                   st_tick, conv_busy, conv_done, conv_start, eight, thr_mode, crossed;
  logic                   fin, restart, kick, h_serve, s_wr, last, wr_en, cmd_go;
  logic                   wr_cmd, wr_test, wr_res, wr_sc, wr_cnt, wr_tp, wr_rp;
  logic signed [12:0]     off_s, adj_s;
  logic [9:0]             val10, val_w;
  logic [7:0]             wr_addr;
  logic [15:0]            wr_data;
  function automatic logic [15:0] rd_fn(input logic [7:0] a);
    logic [15:0] r;
    r = 16'h0000;
    if (a == `ADTS_OFF_RESULT) begin
      r = {res_val_q, 2'b00, conv_busy, res_ch_q};
    end else if (a == `ADTS_OFF_CMD) begin
      r = {8'h00, cmd_q};
    end else if (a == `ADTS_OFF_TEST) begin
      r = {12'h000, test_q};
    end else if (a == `ADTS_OFF_SCTRL) begin
      r = {13'h0000, sc_q};
    end else if (a == `ADTS_OFF_SCOUNT) begin
      r = {8'h00, cnt_q};
    end else if (a == `ADTS_OFF_STABLE) begin
      r = tp_q;
    end else if (a == `ADTS_OFF_SREG) begin
      r = {8'h00, rp_q};
    end
    return r;
  endfunction : rd_fn
  // state-time divider
  assign st_tick = (div_q == `ADTS_DIV_LAST);
  // analog selection straight from register flops
  assign ana_ch_o   = cmd_q[2:0];
  assign ana_test_o = test_q[`ADTS_TST_EN];
  assign ana_ref_o  = test_q[`ADTS_TST_REF];
  // offset in half-lsb steps; raw input carries one extra fraction bit
  assign off_s = (test_q[3:2] == `ADTS_OFF_P25) ? 13'sd1 :
                 (test_q[3:2] == `ADTS_OFF_M25) ? -13'sd1 :
                 (test_q[3:2] == `ADTS_OFF_M50) ? -13'sd2 : 13'sd0;
  assign adj_s = $signed({2'b00, ana_raw_i}) + off_s;
  // saturate rather than wrap at both ends of the scale
  assign val10 = adj_s[12] ? 10'h000 : adj_s[11] ? 10'h3FF : adj_s[10:1];
  assign eight = cmd_q[`ADTS_CMD_DIR] && !cmd_q[`ADTS_CMD_THR];
  assign val_w = eight ? {val10[9:2], 2'b00} : val10;
  assign thr_mode = cmd_q[`ADTS_CMD_THR];
  assign crossed  = cmd_q[`ADTS_CMD_DIR] ? (val_w < res_val_q)
                                         : (val_w > res_val_q);
  assign fin      = conv_done && (!thr_mode || crossed);
  assign restart  = conv_done && thr_mode && !crossed;
  assign kick     = fin && sc_q[`ADTS_SC_SEL];
  // register write port shared by host and scan server
  assign h_serve = hpend_q && (sv_q == SV_IDLE) && !kick;
  assign s_wr    = (sv_q == SV_WRTBL) && bus.mem_ack;
  assign last    = (cnt_q == `ADTS_CNT_ONE);
  assign wr_en   = s_wr || (h_serve && hwe_q);
  assign wr_addr = s_wr ? rp_q + `ADTS_REG_STEP : haddr_q;
  assign wr_data = s_wr ? {8'h00, sav_q} : hwd_q;
  assign wr_cmd  = wr_en && (wr_addr == `ADTS_OFF_CMD);
  assign wr_test = wr_en && (wr_addr == `ADTS_OFF_TEST);
  assign wr_res  = wr_en && (wr_addr == `ADTS_OFF_RESULT);
  assign wr_sc   = wr_en && !s_wr && (wr_addr == `ADTS_OFF_SCTRL);
  assign wr_cnt  = wr_en && !s_wr && (wr_addr == `ADTS_OFF_SCOUNT);
  assign wr_tp   = wr_en && !s_wr && (wr_addr == `ADTS_OFF_STABLE);
  assign wr_rp   = wr_en && !s_wr && (wr_addr == `ADTS_OFF_SREG);
  assign cmd_go  = wr_cmd && (wr_data[7:0] != `ADTS_CMD_NONE);
  assign conv_start = !wr_cmd && (((cv_q == CV_TICK) && st_tick) ||
                      ((cv_q == CV_EPA) && epa_trig_i) || restart);
  adts_conv adts_conv_inst (
    .mclk_i  (mclk_i),
    .rst_b_i (rst_b_i),
    .tick_i  (st_tick),
    .start_i (conv_start),
    .abort_i (wr_cmd),
    .busy_o  (conv_busy),
    .done_o  (conv_done)
  );
  assign bus.reg_ack   = ack_q;
  assign bus.reg_rdata = rdata_q;
  assign bus.mem_req   = mreq_q;
  assign bus.mem_we    = mwe_q;
  assign bus.mem_addr  = maddr_q;
  assign bus.mem_wdata = mwd_q;
  assign bus.done      = int_q;
  assign bus.srv       = sc_q[`ADTS_SC_SRV];
  assign conv_int_o    = int_q;
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_q <= '0;
    end else begin
      div_q <= st_tick ? '0 : div_q + 1'b1;
    end
  end
  // conversion request state
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cv_q <= CV_IDLE;
    end else if (wr_cmd) begin
      if (cmd_go) begin
        cv_q <= wr_data[`ADTS_CMD_GO] ? CV_TICK : CV_EPA;
      end else begin
        cv_q <= CV_IDLE;
      end
    end else begin
      case (cv_q)
        CV_TICK: if (st_tick) cv_q <= CV_RUN;
        CV_EPA:  if (epa_trig_i) cv_q <= CV_RUN;
        CV_RUN:  if (fin) cv_q <= CV_IDLE;
        default: cv_q <= CV_IDLE;
      endcase
    end
  end
  // converter registers
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cmd_q     <= 8'h00;
      test_q    <= 4'h0;
      res_val_q <= 10'h000;
      res_ch_q  <= 3'h0;
      int_q     <= 1'b0;
    end else begin
      int_q <= (fin && !sc_q[`ADTS_SC_SEL]) || (s_wr && last);
      if (wr_cmd) begin
        cmd_q <= wr_data[7:0];
      end
      if (wr_test) begin
        test_q <= wr_data[3:0];
      end
      if (conv_done) begin
        res_ch_q <= cmd_q[2:0];
      end
      if (wr_res) begin
        res_val_q <= wr_data[15:`ADTS_RES_VAL_LO];
      end else if (conv_done && !thr_mode) begin
        res_val_q <= val_w;
      end
    end
  end
  // scan control block
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sc_q  <= 3'h0;
      cnt_q <= 8'h00;
      tp_q  <= 16'h0000;
      rp_q  <= 8'h00;
    end else begin
      if (wr_sc) begin
        sc_q <= wr_data[2:0];
      end else if (s_wr && last) begin
        sc_q[`ADTS_SC_SEL] <= 1'b0;
        sc_q[`ADTS_SC_SRV] <= 1'b1;
      end
      if (wr_cnt) begin
        cnt_q <= wr_data[7:0];
      end else if (s_wr) begin
        cnt_q <= cnt_q - 1'b1;
      end
      if (wr_tp) begin
        tp_q <= wr_data;
      end else if ((sv_q == SV_RDCMD) && bus.mem_ack) begin
        tp_q <= tp_q + `ADTS_PTR_STEP;
      end else if (s_wr && sc_q[`ADTS_SC_UPD]) begin
        tp_q <= tp_q + `ADTS_PTR_STEP;
      end
      if (wr_rp) begin
        rp_q <= wr_data[7:0];
      end
    end
  end
  // scan server sequence; a cycle is kicked only by a finished conversion
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sv_q    <= SV_IDLE;
      sav_q   <= 8'h00;
      mreq_q  <= 1'b0;
      mwe_q   <= 1'b0;
      maddr_q <= 16'h0000;
      mwd_q   <= 16'h0000;
    end else begin
      mreq_q <= 1'b0;
      case (sv_q)
        SV_IDLE: if (kick) begin
          mreq_q  <= 1'b1;
          mwe_q   <= 1'b0;
          maddr_q <= tp_q;
          sv_q    <= SV_RDCMD;
        end
        SV_RDCMD: if (bus.mem_ack) begin
          sav_q <= bus.mem_rdata[7:0];
          sv_q  <= SV_RDREG;
        end
        SV_RDREG: begin
          mreq_q  <= 1'b1;
          mwe_q   <= 1'b1;
          maddr_q <= tp_q;
          mwd_q   <= rd_fn(rp_q);
          sv_q    <= SV_WRTBL;
        end
        SV_WRTBL: if (bus.mem_ack) sv_q <= SV_IDLE;
        default: sv_q <= SV_IDLE;
      endcase
    end
  end
  // host access: held until the server is idle, answered one cycle later
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hpend_q <= 1'b0;
      hwe_q   <= 1'b0;
      haddr_q <= 8'h00;
      hwd_q   <= 16'h0000;
      ack_q   <= 1'b0;
      rdata_q <= 16'h0000;
    end else begin
      ack_q <= h_serve;
      if (bus.reg_req) begin
        hpend_q <= 1'b1;
        hwe_q   <= bus.reg_we;
        haddr_q <= bus.reg_addr;
        hwd_q   <= bus.reg_wdata;
      end else if (h_serve) begin
        hpend_q <= 1'b0;
      end
      if (h_serve) begin
        rdata_q <= rd_fn(haddr_q);
      end
    end
  end
endmodule : adts_dev
`default_nettype wire

// ===== logic/adts_if.sv
// link between the cpu end and the converter device end
// assumes both ends run on the same clock
`timescale 1ns/100ps
`default_nettype none
interface adts_if;
  logic        reg_req;
  logic        reg_we;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic        reg_ack;
  logic        mem_req;
  logic        mem_we;
  logic [15:0] mem_addr;
  logic [15:0] mem_wdata;
  logic [15:0] mem_rdata;
  logic        mem_ack;
  logic        done;
  logic        srv;

  modport dev (input reg_req, reg_we, reg_addr, reg_wdata, mem_rdata, mem_ack,
               output reg_rdata, reg_ack, mem_req, mem_we, mem_addr, mem_wdata,
               done, srv);
  modport cpu (output reg_req, reg_we, reg_addr, reg_wdata, mem_rdata, mem_ack,
               input reg_rdata, reg_ack, mem_req, mem_we, mem_addr, mem_wdata,
               done, srv);
endinterface : adts_if
`default_nettype wire

// ===== logic/adts_pkg.sv
// types shared by the converter control ends
// assumes adts_cfg.svh for numeric constants
package adts_pkg;
  typedef enum logic [1:0] {SV_IDLE, SV_RDCMD, SV_RDREG, SV_WRTBL} adts_srv_t;
  typedef enum logic [1:0] {CV_IDLE, CV_TICK, CV_EPA, CV_RUN} adts_cv_t;
endpackage : adts_pkg

// ===== testbench/adc_test_result_scan_bench.sv
// bench: cpu end and device end joined by the link, driven over apb
// assumes 125 MHz clock and the register map of the hand-over
`timescale 1ns/100ps
`default_nettype none
module adc_test_result_scan_bench;
  typedef struct packed {logic [7:0] c; logic [7:0] t; logic [10:0] r; logic [15:0] e;} adts_row_t;
  logic        mclk_i     = 1'b0;
  logic        rst_b_i    = 1'b0;
  logic        epa_trig_i = 1'b0;
  logic [10:0] ana_raw_i  = 11'h000;
  logic [11:0] paddr_i    = 12'h000;
  logic        psel_i     = 1'b0;
  logic        penable_i  = 1'b0;
  logic        pwrite_i   = 1'b0;
  logic [31:0] pwdata_i   = 32'h0;
  logic [31:0] prdata_o, rd;
  logic        pready_o, pslverr_o, err, h, ana_test_o, ana_ref_o, conv_int_o;
  logic [2:0]  ana_ch_o;
  logic [15:0] d;
  int          n, cyc, n_mismatch, compares;
  // cmd, test, sample, expected result; offsets 0,+1,-1,-2 and both clamps
  adts_row_t rows [7] = '{'{8'h08, 8'h00, 11'h2AA, 16'h5540}, '{8'h0D, 8'h04, 11'h101, 16'h2045},
    '{8'h0F, 8'h03, 11'h7FF, 16'hFFC7}, '{8'h0F, 8'h01, 11'h000, 16'h0007},
    '{8'h0A, 8'h0C, 11'h001, 16'h0002}, '{8'h1B, 8'h08, 11'h3FF, 16'h7F03},
    '{8'h0F, 8'h05, 11'h7FF, 16'hFFC7}};
  logic [15:0] ex [3] = '{16'h5542, 16'h5541, 16'h5544};
  adts_if link ();
  adts_dev adts_dev_inst (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .bus(link.dev),
    .epa_trig_i(epa_trig_i), .ana_raw_i(ana_raw_i), .ana_ch_o(ana_ch_o),
    .ana_test_o(ana_test_o), .ana_ref_o(ana_ref_o), .conv_int_o(conv_int_o));
  adts_cpu adts_cpu_inst (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .bus(link.cpu),
    .paddr_i(paddr_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o));
  adts_properties adts_properties_inst (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .reg_req(link.reg_req), .reg_we(link.reg_we), .reg_addr(link.reg_addr),
    .reg_rdata(link.reg_rdata), .reg_ack(link.reg_ack), .mem_req(link.mem_req),
    .mem_we(link.mem_we), .mem_addr(link.mem_addr), .mem_ack(link.mem_ack),
    .done(link.done), .srv(link.srv));
  always #4 mclk_i = ~mclk_i;
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict
  // a hang shows as a missing pready; a missing done ends wait_done at its limit
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] v);
    paddr_i <= a;
    pwrite_i <= w;
    pwdata_i <= v;
    psel_i <= 1'b1;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge mclk_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge mclk_i);
  endtask : apb
  task automatic dwr(input logic [7:0] o, input logic [15:0] v);
    apb(12'h004, 1'b1, {16'h0000, v});
    apb(12'h000, 1'b1, {23'h0, 1'b1, o});
  endtask : dwr
  task automatic drd(input logic [7:0] o);
    apb(12'h000, 1'b1, {23'h0, 1'b0, o});
    apb(12'h004, 1'b0, 32'h0);
    d = rd[15:0];
  endtask : drd
  task automatic wait_done(input int lim);
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (conv_int_o !== 1'b1 && n < lim);
    h = conv_int_o;
  endtask : wait_done
  initial begin
    repeat (4) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    @(posedge mclk_i);
    foreach (rows[i]) begin
      ana_raw_i <= rows[i].r;
      dwr(8'h0E, {8'h00, rows[i].t});
      dwr(8'h0C, {8'h00, rows[i].c});
      wait_done(400);
      chk("done", 1, h);
      chk("ch out", rows[i].c[2:0], ana_ch_o);
      chk("test out", rows[i].t[1:0], {ana_ref_o, ana_test_o});
      drd(8'h0A);
      chk("result", rows[i].e, d);
    end
    $display("table rows done");
    dwr(8'h0C, 16'h0009);
    repeat (60) @(posedge mclk_i);
    drd(8'h0A);
    chk("busy", 1, d[3]);
    dwr(8'h0C, 16'h000C);
    wait_done(400);
    chk("restart", 1, h && n > 150);
    drd(8'h0A);
    chk("restart ch", 4, d[3:0]);
    $display("abort test done");
    dwr(8'h0C, 16'h0001);
    wait_done(200);
    chk("armed idle", 0, h);
    epa_trig_i <= 1'b1;
    @(posedge mclk_i);
    epa_trig_i <= 1'b0;
    wait_done(400);
    chk("event start", 1, h);
    $display("event test done");
    for (int k = 0; k < 2; k++) begin
      ana_raw_i <= (k == 0) ? 11'h100 : 11'h600;
      dwr(8'h0A, 16'h8000);
      dwr(8'h0C, {10'h0, 1'b1, k[0], 4'h8});
      wait_done(400);
      chk("thr hold", 0, h);
      ana_raw_i <= (k == 0) ? 11'h600 : 11'h100;
      wait_done(400);
      chk("thr hit", 1, h);
      wait_done(400);
      chk("thr stop", 0, h);
    end
    $display("threshold test done");
    dwr(8'h0E, 16'h0000);
    ana_raw_i <= 11'h2AA;
    apb(12'h080, 1'b1, 32'h0009);
    apb(12'h088, 1'b1, 32'h000C);
    apb(12'h090, 1'b1, 32'h0000);
    dwr(8'h14, 16'h0000);
    dwr(8'h16, 16'h000A);
    dwr(8'h12, 16'h0003);
    dwr(8'h10, 16'h0005);
    dwr(8'h0C, 16'h000A);
    wait_done(1000);
    chk("scan end", 1, h);
    for (int j = 0; j < 3; j++) begin
      apb(12'h084 + 12'(8 * j), 1'b0, 32'h0);
      chk("table", ex[j], rd[15:0]);
    end
    drd(8'h10);
    chk("scan ctrl", 16'h0006, d);
    drd(8'h14);
    chk("table ptr", 16'h000C, d);
    apb(12'h008, 1'b0, 32'h0);
    chk("service", 1, rd[1]);
    chk("evt sticky", 1, rd[0]);
    apb(12'h008, 1'b1, 32'h0000_0001);
    apb(12'h008, 1'b0, 32'h0);
    chk("evt clear", 0, rd[0]);
    wait_done(300);
    chk("dummy cmd", 0, h);
    $display("scan test done");
    apb(12'h00C, 1'b0, 32'h0);
    chk("slverr", 1, err);
    drd(8'h20);
    chk("unmapped", 0, d);
    dwr(8'h0E, 16'h0003);
    dwr(8'h0C, 16'h0007);
    rst_b_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    @(posedge mclk_i);
    drd(8'h0E);
    chk("reset", 0, {d, ana_ch_o, ana_test_o, ana_ref_o});
    $display("reset test done");
    give_verdict();
  end
endmodule : adc_test_result_scan_bench
`default_nettype wire

// ===== testbench/adts_properties.sv
// checker on the link between cpu end and device end
// assumes one clock; instantiated beside the link in the bench
`timescale 1ns/100ps
`default_nettype none
`include "adts_cfg.svh"
module adts_properties (
  input wire logic        mclk_i,
  input wire logic        rst_b_i,
  input wire logic        reg_req,
  input wire logic        reg_we,
  input wire logic [7:0]  reg_addr,
  input wire logic [15:0] reg_rdata,
  input wire logic        reg_ack,
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic        mem_ack,
  input wire logic        done,
  input wire logic        srv
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  // read data comes later than the address, so keep it
  logic [7:0] addr_q;
  logic       rd_q;
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      addr_q <= 8'h00;
      rd_q <= 1'b0;
    end else if (reg_req) begin
      addr_q <= reg_addr;
      rd_q <= !reg_we;
    end
  end
  a_req_gets_ack: assert property (reg_req |-> ##[1:20] reg_ack)
    else $error("device access not answered");
  a_mem_ack_next: assert property (mem_req |=> mem_ack)
    else $error("table access not answered");
  a_mem_word_addr: assert property (mem_req |-> !mem_addr[0])
    else $error("odd table address");
  a_table_step: assert property (mem_req && !mem_we |-> ##3 (mem_req && mem_we
    && mem_addr == $past(mem_addr, 3) + `ADTS_PTR_STEP)) else $error("table step wrong");
  a_done_alone: assert property (done |=> !done [*8])
    else $error("done repeated");
  a_srv_done: assert property ($rose(srv) |-> ##[0:2] done)
    else $error("service without done");
  a_result_resv: assert property (reg_ack && rd_q && addr_q == `ADTS_OFF_RESULT
    |-> reg_rdata[5:4] == 2'b00) else $error("result bits 5:4 set");
  a_test_upper: assert property (reg_ack && rd_q && addr_q == `ADTS_OFF_TEST
    |-> reg_rdata[15:4] == 12'h000) else $error("test upper bits set");
endmodule : adts_properties
`default_nettype wire
